/* usb_buf_pkg.sv */
// Constants and carrier types for the pipe buffer manager.
// Assumes a 32-bit APB register bus and one serial engine client.
package usb_buf_pkg;
    localparam int NPIPE = 10;       // Control pipe plus pipes 1-9
    localparam int IXW = 12;         // Word index width
    localparam int MEM_WORDS = 2176; // 136 blocks of 16 words
    localparam int BLK_SHIFT = 4;    // 64-byte block = 16 words
    localparam logic [3:0] CTRL_PIPE = 4'h0;
    localparam logic [3:0] USER_LO = 4'h1;
    localparam logic [3:0] USER_HI = 4'h5;
    localparam logic [3:0] FIXED_LO = 4'h6;
    localparam logic [7:0] CTRL_START = 8'h00;
    localparam logic [6:0] CTRL_BLKS_M1 = 7'h03;
    localparam logic [7:0] FIXED_START = 8'h04;
    localparam logic [6:0] FIXED_BLKS_M1 = 7'h00;
    // Register byte offsets
    localparam logic [11:0] SEL_OFS = 12'h000;
    localparam logic [11:0] CTL_OFS = 12'h004;
    localparam logic [11:0] ENG_OFS = 12'h008;
    localparam logic [11:0] DATA_OFS = 12'h00C;
    localparam logic [11:0] CFG_BASE = 12'h040;
    localparam logic [11:0] PCTL_BASE = 12'h080;
    localparam logic [11:0] PBUF_BASE = 12'h0C0;
    // Field positions
    localparam int F_CUR = 0;
    localparam int F_CDIR = 8;
    localparam int F_DCLR = 9;
    localparam int F_WEND = 0;
    localparam int F_CPU_SIDE_CLEAR = 1;
    localparam int F_FRDY = 16;
    localparam int F_ENGINE_SIDE_CLEAR = 0;
    localparam int F_DIR = 0;
    localparam int F_DBL = 1;
    localparam int F_CNT = 2;
    localparam int F_MPS = 8;
    localparam int F_ACLR = 0;
    localparam int F_BUFFER_ACCESS_STATUS = 8;
    localparam int F_INBUF = 9;
    localparam int F_START = 0;
    localparam int F_BSZ = 8;
    // Per-pipe settings
    typedef struct packed {
        logic dir;
        logic dbl;
        logic cnt;
        logic aclr;
        logic [4:0] mps;
        logic [7:0] start;
        logic [6:0] bsz;
    } pipe_cfg_t;
    // One buffer bank
    typedef struct packed {
        logic full;
        logic zlp;
        logic [IXW-1:0] len;
    } bank_t;
    // Both banks plus the two side pointers
    typedef struct packed {
        bank_t [1:0] bk;
        logic cs;
        logic es;
        logic [IXW-1:0] ci;
        logic [IXW-1:0] ei;
        logic [4:0] pk;
    } pipe_buf_t;
    // Serial engine requests
    typedef struct packed {
        logic rx_wr;
        logic rx_end;
        logic rx_short;
        logic txn_done;
        logic tx_rd;
        logic [3:0] pipe;
        logic [31:0] rx_data;
    } eng_req_t;
    // Answer to the serial engine
    typedef struct packed {
        logic tx_valid;
        logic tx_last;
        logic [31:0] tx_data;
    } eng_rsp_t;
    // Whole block state
    typedef struct packed {
        pipe_cfg_t [NPIPE-1:0] cfg;
        pipe_buf_t [NPIPE-1:0] pb;
        logic [3:0] cur;
        logic cdir;
        logic dclr;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        eng_rsp_t rsp;
        logic [NPIPE-1:0] txr;
        logic [NPIPE-1:0] rxr;
    } state_t;
endpackage : usb_buf_pkg

/* usb_pipe_buffer_manager.sv */
// Pipe buffer manager: shared packet memory, APB CPU port, engine side.
// Assumes engine requests are synchronous to sys_clk.
//
// How it works
// - Direction bit 0 receive, 1 send
// - Receive empty or busy: status 0, no reads
// - Receive data: status 1; empty packet blocks reads
// - Send busy status 0; done status 1, writable
// - In-buffer flag only on send pipes 1-5
// - In-buffer flag set while send data waits
// - Double send: status CPU bank, flag engine bank
// - Clear bits empty CPU or engine bank
// - Auto-clear after read on the selected CPU port
// - Auto-clear bit 1 then 0 clears engine bank
// - Blocks 0-3 fixed for control pipe
// - Blocks 4-7 fixed for pipes 6-9
// - Blocks 8-0x87 user area, pipes 1-5
// - Pipes 1-5 single or double buffered
// - Continuous mode only on pipes 0-5
// - Continuous mode fills whole buffer
// - Continuous send splits at max packet size
// - Continuous receive completes on full/count/short
// - Areas placed by block start and count
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module usb_pipe_buffer_manager
    import usb_buf_pkg::*;
(
    input logic sys_clk,
    input logic rst_n,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input eng_req_t eng_req,
    output eng_rsp_t eng_rsp,
    output logic [NPIPE-1:0] eng_tx_ready,
    output logic [NPIPE-1:0] eng_rx_ready
);
    state_t st_reg;                     // All control state
    state_t st_next;                    // Next value of it
    logic [31:0] mem [MEM_WORDS];       // Shared packet memory
    logic cw_en;                        // CPU write strobe
    logic [IXW-1:0] cw_a;               // CPU write address
    logic ew_en;                        // Engine write strobe
    logic [IXW-1:0] ew_a;               // Engine write address

    // Pipe 1-5 check
    function automatic logic is_user(logic [3:0] p);
        return p >= USER_LO && p <= USER_HI;
    endfunction : is_user

    // Control pipe takes the port direction bit
    function automatic logic pdir(state_t s, logic [3:0] p);
        return (p == CTRL_PIPE) ? s.cdir : s.cfg[p].dir;
    endfunction : pdir

    // Double buffering only exists on user pipes
    function automatic logic pdbl(state_t s, logic [3:0] p);
        return is_user(p) & s.cfg[p].dbl;
    endfunction : pdbl

    // Continuous mode only on pipes 0-5
    function automatic logic pcnt(state_t s, logic [3:0] p);
        return (p <= USER_HI) & s.cfg[p].cnt;
    endfunction : pcnt

    // Area size in blocks minus one
    function automatic logic [6:0] bm1(state_t s, logic [3:0] p);
        if (p == CTRL_PIPE) begin
            return CTRL_BLKS_M1;
        end else if (p >= FIXED_LO) begin
            return FIXED_BLKS_M1;
        end
        return s.cfg[p].bsz;
    endfunction : bm1

    // First block of the area
    function automatic logic [7:0] sblk(state_t s, logic [3:0] p);
        if (p == CTRL_PIPE) begin
            return CTRL_START;
        end else if (p >= FIXED_LO) begin
            return FIXED_START + 8'(p - FIXED_LO);
        end
        return s.cfg[p].start;
    endfunction : sblk

    // Bank capacity in words
    function automatic logic [IXW-1:0] cap(state_t s, logic [3:0] p);
        return (IXW'(bm1(s, p)) + 1'b1) << BLK_SHIFT;
    endfunction : cap

    // Word address; second bank follows the first
    function automatic logic [IXW-1:0] waddr(state_t s, logic [3:0] p,
                                             logic b, logic [IXW-1:0] ix);
        logic [7:0] blk;
        blk = sblk(s, p) + (b ? 8'(bm1(s, p)) + 8'h01 : 8'h00);
        return (IXW'(blk) << BLK_SHIFT) + ix;
    endfunction : waddr

    // Register window hit and pipe index
    function automatic logic win(logic [11:0] a, logic [11:0] base);
        return a >= base && a < base + 12'(NPIPE * 4) && a[1:0] == 2'h0;
    endfunction : win

    // Empty the engine-side bank
    function automatic pipe_buf_t eclr(pipe_buf_t x);
        x.bk[x.es] = '0;
        x.ei = '0;
        x.pk = '0;
        return x;
    endfunction : eclr

    // CPU access status, shown as the buffer status bit
    function automatic logic buffer_access_status(state_t s, logic [3:0] p);
        bank_t k;
        k = s.pb[p].bk[s.pb[p].cs];
        return pdir(s, p) ? ~k.full : k.full;
    endfunction : buffer_access_status

    // Send data still held; engine bank when double
    function automatic logic inbuf(state_t s, logic [3:0] p);
        pipe_buf_t x;
        x = s.pb[p];
        if (!is_user(p) || !pdir(s, p)) begin
            return 1'b0;
        end else if (pdbl(s, p)) begin
            return x.bk[x.es].full;
        end
        return x.bk[0].full | (x.ci != '0);
    endfunction : inbuf

    // Next state
    always_comb begin
        logic [3:0] p;
        logic [3:0] e;
        logic [3:0] ri;
        logic b;
        logic eb;
        logic acc;
        logic [IXW-1:0] lim;
        p = st_reg.cur;
        e = eng_req.pipe;
        ri = '0;
        b = st_reg.pb[p].cs;
        eb = 1'b0;
        acc = psel & penable & ~st_reg.pready;
        lim = '0;
        st_next = st_reg;
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;
        st_next.rsp = '0;
        cw_en = 1'b0;
        cw_a = '0;
        ew_en = 1'b0;
        ew_a = '0;
        if (acc) begin
            st_next.pready = 1'b1;
            st_next.prdata = '0;
            // Port select
            if (paddr == SEL_OFS) begin
                if (pwrite) begin
                    if (pwdata[F_CUR +: 4] < 4'(NPIPE)) begin
                        st_next.cur = pwdata[F_CUR +: 4];
                    end
                    st_next.cdir = pwdata[F_CDIR];
                    st_next.dclr = pwdata[F_DCLR];
                end else begin
                    st_next.prdata[F_CUR +: 4] = st_reg.cur;
                    st_next.prdata[F_CDIR] = st_reg.cdir;
                    st_next.prdata[F_DCLR] = st_reg.dclr;
                end
            // Port control: clear first so clear plus end sends empty
            end else if (paddr == CTL_OFS) begin
                if (pwrite) begin
                    if (pwdata[F_CPU_SIDE_CLEAR]) begin
                        st_next.pb[p].bk[b] = '0;
                        st_next.pb[p].ci = '0;
                    end
                    if (pwdata[F_WEND] && pdir(st_reg, p) &&
                        !st_reg.pb[p].bk[b].full) begin
                        st_next.pb[p].bk[b].full = 1'b1;
                        st_next.pb[p].bk[b].zlp = (st_next.pb[p].ci == '0);
                        st_next.pb[p].bk[b].len = st_next.pb[p].ci;
                        st_next.pb[p].ci = '0;
                        st_next.pb[p].cs = b ^ pdbl(st_reg, p);
                    end
                end else begin
                    st_next.prdata[F_FRDY] = buffer_access_status(st_reg, p) &
                        ~(st_reg.pb[p].bk[b].zlp & ~pdir(st_reg, p));
                    st_next.prdata[IXW-1:0] = st_reg.pb[p].bk[b].len;
                end
            // Engine-side clear of the selected pipe
            end else if (paddr == ENG_OFS) begin
                if (pwrite && pwdata[F_ENGINE_SIDE_CLEAR]) begin
                    st_next.pb[p] = eclr(st_reg.pb[p]);
                end
            // Data window
            end else if (paddr == DATA_OFS) begin
                lim = pcnt(st_reg, p) ? cap(st_reg, p) :
                      IXW'(st_reg.cfg[p].mps);
                if (pwrite) begin
                    if (pdir(st_reg, p) && !st_reg.pb[p].bk[b].full) begin
                        cw_en = 1'b1;
                        cw_a = waddr(st_reg, p, b, st_reg.pb[p].ci);
                        st_next.pb[p].ci = st_reg.pb[p].ci + 1'b1;
                        // Full bank hands itself to the engine
                        if (st_next.pb[p].ci == lim) begin
                            st_next.pb[p].bk[b].full = 1'b1;
                            st_next.pb[p].bk[b].zlp = 1'b0;
                            st_next.pb[p].bk[b].len = lim;
                            st_next.pb[p].ci = '0;
                            st_next.pb[p].cs = b ^ pdbl(st_reg, p);
                        end
                    end
                end else if (!pdir(st_reg, p) &&
                             st_reg.pb[p].bk[b].full &&
                             !st_reg.pb[p].bk[b].zlp) begin
                    st_next.prdata = mem[waddr(st_reg, p, b,
                                               st_reg.pb[p].ci)];
                    st_next.pb[p].ci = st_reg.pb[p].ci + 1'b1;
                    // Last word read frees the bank
                    if (st_next.pb[p].ci == st_reg.pb[p].bk[b].len) begin
                        st_next.pb[p].bk[b] = '0;
                        st_next.pb[p].ci = '0;
                        st_next.pb[p].cs = b ^ pdbl(st_reg, p);
                    end
                end
            // Pipe settings
            end else if (win(paddr, CFG_BASE)) begin
                ri = 4'((paddr - CFG_BASE) >> 2);
                if (pwrite) begin
                    st_next.cfg[ri].dir = pwdata[F_DIR];
                    st_next.cfg[ri].dbl = pwdata[F_DBL];
                    st_next.cfg[ri].cnt = pwdata[F_CNT];
                    st_next.cfg[ri].mps = pwdata[F_MPS +: 5];
                end else begin
                    st_next.prdata[F_DIR] = st_reg.cfg[ri].dir;
                    st_next.prdata[F_DBL] = pdbl(st_reg, ri);
                    st_next.prdata[F_CNT] = pcnt(st_reg, ri);
                    st_next.prdata[F_MPS +: 5] = st_reg.cfg[ri].mps;
                end
            // Pipe control and status
            end else if (win(paddr, PCTL_BASE)) begin
                ri = 4'((paddr - PCTL_BASE) >> 2);
                if (pwrite) begin
                    st_next.cfg[ri].aclr = pwdata[F_ACLR];
                    // Falling auto-clear bit empties the engine bank
                    if (st_reg.cfg[ri].aclr && !pwdata[F_ACLR]) begin
                        st_next.pb[ri] = eclr(st_reg.pb[ri]);
                    end
                end else begin
                    st_next.prdata[F_ACLR] = st_reg.cfg[ri].aclr;
                    st_next.prdata[F_BUFFER_ACCESS_STATUS] = buffer_access_status(st_reg, ri);
                    st_next.prdata[F_INBUF] = inbuf(st_reg, ri);
                end
            // Area placement
            end else if (win(paddr, PBUF_BASE)) begin
                ri = 4'((paddr - PBUF_BASE) >> 2);
                if (pwrite) begin
                    st_next.cfg[ri].start = pwdata[F_START +: 8];
                    st_next.cfg[ri].bsz = pwdata[F_BSZ +: 7];
                end else begin
                    st_next.prdata[F_START +: 8] = sblk(st_reg, ri);
                    st_next.prdata[F_BSZ +: 7] = bm1(st_reg, ri);
                end
            end else begin
                st_next.pslverr = 1'b1; // Unmapped address
            end
        end
        // Empty packets cannot be read, so auto-clear drops them
        b = st_next.pb[p].cs;
        if (st_reg.dclr && !pdir(st_next, p) &&
            st_next.pb[p].bk[b].zlp) begin
            st_next.pb[p].bk[b] = '0;
        end
        // Engine runs last so its events survive a same-cycle clear
        eb = st_next.pb[e].es;
        if (e < 4'(NPIPE) && !pdir(st_next, e) &&
            !st_next.pb[e].bk[eb].full) begin
            if (eng_req.rx_wr) begin
                ew_en = 1'b1;
                ew_a = waddr(st_next, e, eb, st_next.pb[e].ei);
                st_next.pb[e].ei = st_next.pb[e].ei + 1'b1;
            end
            if (eng_req.rx_end && st_next.pb[e].ei == '0) begin
                st_next.pb[e].bk[eb].full = 1'b1;
                st_next.pb[e].bk[eb].zlp = 1'b1;
                st_next.pb[e].bk[eb].len = '0;
                st_next.pb[e].es = eb ^ pdbl(st_next, e);
            end else if (st_next.pb[e].ei != '0 &&
                         ((eng_req.rx_end && (!pcnt(st_next, e) ||
                           eng_req.rx_short)) || eng_req.txn_done ||
                          st_next.pb[e].ei == cap(st_next, e))) begin
                st_next.pb[e].bk[eb].full = 1'b1;
                st_next.pb[e].bk[eb].len = st_next.pb[e].ei;
                st_next.pb[e].ei = '0;
                st_next.pb[e].es = eb ^ pdbl(st_next, e);
            end
        end else if (e < 4'(NPIPE) && eng_req.tx_rd &&
                     pdir(st_next, e) && st_next.pb[e].bk[eb].full) begin
            st_next.rsp.tx_last = 1'b1;
            if (st_next.pb[e].bk[eb].len != '0) begin
                st_next.rsp.tx_valid = 1'b1;
                st_next.rsp.tx_data = mem[waddr(st_next, e, eb,
                                                st_next.pb[e].ei)];
                st_next.pb[e].ei = st_next.pb[e].ei + 1'b1;
                st_next.pb[e].pk = st_next.pb[e].pk + 1'b1;
                st_next.rsp.tx_last =
                    (st_next.pb[e].pk == st_next.cfg[e].mps) ||
                    (st_next.pb[e].ei == st_next.pb[e].bk[eb].len);
                if (st_next.rsp.tx_last) begin
                    st_next.pb[e].pk = '0;
                end
            end
            // Bank sent out: give it back to the CPU side
            if (st_next.pb[e].ei == st_next.pb[e].bk[eb].len) begin
                st_next.pb[e] = eclr(st_next.pb[e]);
                st_next.pb[e].es = eb ^ pdbl(st_next, e);
            end
        end
        // Engine-side readiness, registered for the engine
        for (int i = 0; i < NPIPE; i++) begin
            eb = st_next.pb[i].es;
            st_next.txr[i] = pdir(st_next, 4'(i)) &
                             st_next.pb[i].bk[eb].full;
            st_next.rxr[i] = ~pdir(st_next, 4'(i)) &
                             ~st_next.pb[i].bk[eb].full;
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Packet memory; no reset, contents are don't-care until written
    always_ff @(posedge sys_clk) begin
        if (cw_en) begin
            mem[cw_a] <= pwdata;
        end
        if (ew_en) begin
            mem[ew_a] <= eng_req.rx_data;
        end
    end

    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign eng_rsp = st_reg.rsp;
    assign eng_tx_ready = st_reg.txr;
    assign eng_rx_ready = st_reg.rxr;

    // Helpers read only by the checks below
    logic acc_h;
    logic [3:0] pi_h;
    bank_t cb_h;
    bank_t eb_h;
    assign acc_h = psel & penable & ~st_reg.pready;
    assign pi_h = 4'((paddr - PCTL_BASE) >> 2);
    assign cb_h = st_reg.pb[st_reg.cur].bk[st_reg.pb[st_reg.cur].cs];
    assign eb_h = st_reg.pb[eng_req.pipe].bk[st_reg.pb[eng_req.pipe].es];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_data_rd;
        acc_h && !pwrite && paddr == DATA_OFS;
    endsequence
    sequence s_aclr_fall;
        acc_h && pwrite && win(paddr, PCTL_BASE) &&
        st_reg.cfg[pi_h].aclr && !pwdata[F_ACLR];
    endsequence

    property p_rx_refused;
        s_data_rd and (!(!pdir(st_reg, st_reg.cur) && cb_h.full))
        |=> pready && prdata == '0;
    endproperty
    a_rx_refused: assert property (p_rx_refused)
        else $error("read taken from empty receive buffer");
    property p_zlp_hold;
        s_data_rd and (!pdir(st_reg, st_reg.cur) && cb_h.zlp)
        |=> prdata == '0 ##1 $stable(st_reg.pb[st_reg.cur].ci);
    endproperty
    a_zlp_hold: assert property (p_zlp_hold)
        else $error("empty packet was readable");
    property p_tx_full_block;
        acc_h && pwrite && paddr == DATA_OFS &&
        pdir(st_reg, st_reg.cur) && cb_h.full |-> !cw_en;
    endproperty
    a_tx_full_block: assert property (p_tx_full_block)
        else $error("write into a bank still sending");
    property p_inbuf_scope;
        !inbuf(st_reg, CTRL_PIPE) && !inbuf(st_reg, FIXED_LO) &&
        (pdir(st_reg, USER_LO) || !inbuf(st_reg, USER_LO));
    endproperty
    a_inbuf_scope: assert property (p_inbuf_scope)
        else $error("in-buffer flag outside send pipes 1-5");
    property p_cpu_clear;
        acc_h && pwrite && paddr == CTL_OFS && pwdata[F_CPU_SIDE_CLEAR] &&
        !pwdata[F_WEND] && !pdir(st_reg, st_reg.cur) &&
        !eng_req.rx_wr && !eng_req.rx_end && !eng_req.txn_done
        |=> !cb_h.full;
    endproperty
    a_cpu_clear: assert property (p_cpu_clear)
        else $error("cpu side clear left data");
    // Engine word in the same cycle wins, so leave that case out
    property p_aclr_clear;
        s_aclr_fall and (!eng_req.rx_wr && !eng_req.tx_rd)
        |=> st_reg.pb[$past(pi_h)].ei == '0;
    endproperty
    a_aclr_clear: assert property (p_aclr_clear)
        else $error("auto-clear drop kept engine data");
    property p_fixed_map;
        sblk(st_reg, CTRL_PIPE) == CTRL_START &&
        cap(st_reg, CTRL_PIPE) == (IXW'(CTRL_BLKS_M1) + 1'b1) << BLK_SHIFT
        && sblk(st_reg, FIXED_LO) == FIXED_START;
    endproperty
    a_fixed_map: assert property (p_fixed_map)
        else $error("fixed area misplaced");
    property p_noncont_rx;
        eng_req.rx_end && eng_req.pipe < 4'(NPIPE) &&
        !pdir(st_reg, eng_req.pipe) && !pcnt(st_reg, eng_req.pipe) &&
        !eb_h.full && (st_reg.pb[eng_req.pipe].ei != '0 || eng_req.rx_wr)
        && !acc_h |=> st_reg.pb[$past(eng_req.pipe)].ei == '0;
    endproperty
    a_noncont_rx: assert property (p_noncont_rx)
        else $error("packet not handed to cpu");
    property p_tx_split;
        eng_req.tx_rd && eng_req.pipe < 4'(NPIPE) &&
        pdir(st_reg, eng_req.pipe) && eb_h.full && !acc_h &&
        eb_h.len != '0 &&
        st_reg.pb[eng_req.pipe].pk + 1'b1 == st_reg.cfg[eng_req.pipe].mps
        |=> eng_rsp.tx_valid && eng_rsp.tx_last;
    endproperty
    a_tx_split: assert property (p_tx_split)
        else $error("packet not ended at max size");
endmodule : usb_pipe_buffer_manager

/* serial_engine_model.sv */
// Serial engine model: sends one-cycle requests and returns the answer.
// Assumes the manager samples requests on the rising edge of sys_clk.
`timescale 1ns/1ps
module serial_engine_model
    import usb_buf_pkg::*;
(
    input logic sys_clk,
    input eng_rsp_t eng_rsp,
    output eng_req_t eng_req
);
    // Idle until the bench asks for a transfer
    initial eng_req = '0;
    // One request pulse; the answer is taken two edges after launch
    task automatic send(input eng_req_t r, output eng_rsp_t a);
        @(posedge sys_clk);
        eng_req <= r;
        @(posedge sys_clk);
        eng_req <= '0;
        @(posedge sys_clk);
        a = eng_rsp;
    endtask : send
endmodule : serial_engine_model

/* test_usb_pipe_buffer_manager.sv */
// Bench for the pipe buffer manager: APB master plus engine model.
// Assumes one wait state per APB access and pulse engine requests.
`timescale 1ns/1ps
module test_usb_pipe_buffer_manager;
    import usb_buf_pkg::*;
    logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err;
    eng_req_t eng_req;
    eng_rsp_t eng_rsp, ans;
    logic [NPIPE-1:0] txr, rxr;
    int failures = 0, compares = 0;
    usb_pipe_buffer_manager uut(.sys_clk(sys_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .eng_req(eng_req), .eng_rsp(eng_rsp),
        .eng_tx_ready(txr), .eng_rx_ready(rxr));
    serial_engine_model eng(.sys_clk(sys_clk), .eng_rsp(eng_rsp),
        .eng_req(eng_req));
    // 4 ns clock
    initial forever #2 sys_clk = ~sys_clk;
    // Request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] s);
        compares++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #40000 failures++;
        tally_and_finish;
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        // Ready vector lands one edge after release; look one edge later
        repeat (2) @(posedge sys_clk);
        chk("rx_ready", 32'h3FF, 32'(rxr));
        apb(0, PBUF_BASE, 0);
        chk("ctrl area", 32'h0300, rd);
        for (int i = 6; i < 10; i++) begin
            apb(0, 12'(PBUF_BASE + 4 * i), 0);
            chk("fixed area", 32'(i - 2), rd);
        end
        // Pipe 3 placed on an unused fixed area; modes refused on pipe 6
        apb(1, PBUF_BASE + 12'h00C, 32'h0004);
        apb(0, PBUF_BASE + 12'h00C, 0);
        chk("mapped area", 32'h0004, rd);
        apb(1, CFG_BASE + 12'h018, 32'h0006);
        apb(0, CFG_BASE + 12'h018, 0);
        chk("fixed modes", 0, rd & 32'h6);
        // Pipe 1: receive, two-word packets, first user block
        apb(1, PBUF_BASE + 12'h004, 32'h0008);
        apb(1, CFG_BASE + 12'h004, 32'h0200);
        apb(1, SEL_OFS, 1);
        apb(0, PCTL_BASE + 12'h004, 0);
        chk("rx empty", 0, rd[F_BUFFER_ACCESS_STATUS]);
        eng.send({5'b10000, 4'h1, 32'hA5A50001}, ans);
        eng.send({5'b11000, 4'h1, 32'h5A5A0002}, ans);
        apb(0, PCTL_BASE + 12'h004, 0);
        chk("rx full", 1, rd[F_BUFFER_ACCESS_STATUS]);
        apb(0, DATA_OFS, 0);
        chk("rx word0", 32'hA5A50001, rd);
        apb(0, DATA_OFS, 0);
        chk("rx word1", 32'h5A5A0002, rd);
        apb(0, PCTL_BASE + 12'h004, 0);
        chk("rx drained", 0, rd[F_BUFFER_ACCESS_STATUS]);
        apb(0, DATA_OFS, 0);
        chk("rx refused", 0, rd);
        eng.send({5'b11000, 4'h1, 32'h00000007}, ans);
        apb(1, CTL_OFS, 32'h2);
        apb(0, PCTL_BASE + 12'h004, 0);
        chk("cpu clear", 0, rd[F_BUFFER_ACCESS_STATUS]);
        // Zero-length packet: status set, port stays unreadable
        eng.send({5'b01000, 4'h1, 32'h0}, ans);
        apb(0, PCTL_BASE + 12'h004, 0);
        chk("zlp status", 1, rd[F_BUFFER_ACCESS_STATUS]);
        apb(0, CTL_OFS, 0);
        chk("zlp ready", 0, rd[F_FRDY]);
        apb(0, DATA_OFS, 0);
        chk("zlp read", 0, rd);
        apb(1, CTL_OFS, 32'h2);
        // Half packet dropped by auto-clear 1 then 0
        eng.send({5'b10000, 4'h1, 32'h1}, ans);
        apb(1, PCTL_BASE + 12'h004, 1);
        apb(1, PCTL_BASE + 12'h004, 0);
        eng.send({5'b11000, 4'h1, 32'h2}, ans);
        apb(0, CTL_OFS, 0);
        chk("aclr length", 1, rd[IXW-1:0]);
        // Auto-clear after read drops a zero-length packet
        apb(1, CTL_OFS, 32'h2);
        apb(1, SEL_OFS, 32'h201);
        eng.send({5'b01000, 4'h1, 32'h0}, ans);
        apb(0, PCTL_BASE + 12'h004, 0);
        chk("auto drop", 0, rd[F_BUFFER_ACCESS_STATUS]);
        // Pipe 2: send, one-word packets
        apb(1, PBUF_BASE + 12'h008, 32'h0009);
        apb(1, CFG_BASE + 12'h008, 32'h0101);
        apb(1, SEL_OFS, 2);
        apb(0, PCTL_BASE + 12'h008, 0);
        chk("tx idle", 32'h100, rd & 32'h300);
        apb(1, DATA_OFS, 32'hC0DE0003);
        apb(0, PCTL_BASE + 12'h008, 0);
        chk("tx pending", 32'h200, rd & 32'h300);
        chk("tx_ready", 1, txr[2]);
        eng.send({5'b00001, 4'h2, 32'h0}, ans);
        chk("tx data", 32'hC0DE0003, ans.tx_data);
        chk("tx last", 2'b11, {ans.tx_valid, ans.tx_last});
        apb(0, PCTL_BASE + 12'h008, 0);
        chk("tx done", 32'h100, rd & 32'h300);
        // Continuous send: short data waits for write end
        apb(1, CFG_BASE + 12'h008, 32'h0105);
        apb(1, DATA_OFS, 32'h0BAD0004);
        apb(0, PCTL_BASE + 12'h008, 0);
        chk("cont open", 32'h300, rd & 32'h300);
        apb(1, CTL_OFS, 32'h1);
        apb(0, PCTL_BASE + 12'h008, 0);
        chk("write end", 32'h200, rd & 32'h300);
        eng.send({5'b00001, 4'h2, 32'h0}, ans);
        chk("cont data", 32'h0BAD0004, ans.tx_data);
        apb(0, 12'hFFC, 0);
        chk("unmapped", 1, err);
        tally_and_finish;
    end
endmodule : test_usb_pipe_buffer_manager
